// [ucm_server.sv]
// Server end: unconnected message manager with a connection table.
// Assumes the client keeps a request valid and stable until reqReady is seen,
// and that myAddr is static logic on the mclk domain.
`include "ucm_params.svh"

module ucm_server #(
  parameter int         NCONN     = 4,
  parameter int         POOL      = 4,
  parameter logic [3:0] GROUPS    = 4'hb,
  parameter logic [3:0] FMTS      = 4'h3,
  parameter logic [3:0] DEF_FMT   = `UCM_FMT_8_8,
  parameter logic [15:0] INST_BASE = 16'h0010
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // Own node address
  input  wire logic [`UCM_ADDR_W-1:0] myAddr,
  // Link
  ucm_if.server                       bus,
  // Explicit request delivered to the object layer
  output logic                        objValid,
  output logic [`UCM_SVC_W-1:0]       objService,
  output logic [15:0]                 objClass,
  output logic [15:0]                 objInst,
  output logic                        objToClass,
  // Status
  output logic [7:0]                  connCount
);

  localparam int SW = (NCONN > 1) ? $clog2(NCONN) : 1;

  ucm_pkg::ucm_srv_state_t state_r;
  ucm_pkg::ucm_req_t       rq_r;
  ucm_pkg::ucm_rsp_t       rsp_nxt;
  logic                    reqReady_r;
  logic                    rspValid_r;
  ucm_pkg::ucm_rsp_t       rsp_r;

  logic                   slotUsed_r  [NCONN];
  logic [1:0]             slotGrp_r   [NCONN];
  logic [`UCM_MID_W-1:0]  slotCliId_r [NCONN];
  logic [`UCM_ADDR_W-1:0] slotCliAd_r [NCONN];
  logic [`UCM_MID_W-1:0]  slotSrvId_r [NCONN];

  // Table search results
  logic                  hasFree;
  logic [SW-1:0]         freeSlot;
  logic                  hitFound;
  logic [SW-1:0]         hitSlot;
  logic                  dupHit;
  logic                  idAvail;
  logic [`UCM_MID_W-1:0] allocId;
  logic [POOL-1:0]       idTaken;
  logic                  doOpen;
  logic                  doClose;
  logic                  cliIdBad;

  assign bus.reqReady = reqReady_r;
  assign bus.rspValid = rspValid_r;
  assign bus.rsp      = rsp_r;

  always_comb begin
    hasFree  = 1'b0;
    freeSlot = '0;
    hitFound = 1'b0;
    hitSlot  = '0;
    dupHit   = 1'b0;
    idTaken  = '0;
    for (int i = 0; i < NCONN; i++) begin
      if (!slotUsed_r[i] && !hasFree) begin
        hasFree  = 1'b1;
        freeSlot = SW'(i);
      end
      // RULE9 instance exists
      if (slotUsed_r[i] && (INST_BASE + 16'(i)) == rq_r.inst) begin
        hitFound = 1'b1;
        hitSlot  = SW'(i);
      end
      // RULE15 duplicate pair
      if (slotUsed_r[i] && slotGrp_r[i] != 2'h1 && slotGrp_r[i] != 2'h2
          && slotCliId_r[i] == rq_r.cliId && slotCliAd_r[i] == rq_r.src
          && (rq_r.group == 4'h0 || rq_r.group == 4'h3))
        dupHit = 1'b1;
      for (int k = 0; k < POOL; k++) begin
        if (slotUsed_r[i] && {2'h0, slotGrp_r[i]} == rq_r.group
            && slotSrvId_r[i] == `UCM_MID_W'(k))
          idTaken[k] = 1'b1;
      end
    end
    idAvail = 1'b0;
    allocId = '0;
    // RULE6 allocate from pool
    for (int k = POOL - 1; k >= 0; k--) begin
      if (!idTaken[k]) begin
        idAvail = 1'b1;
        allocId = `UCM_MID_W'(k);
      end
    end
  end

  // Client source ID range depends on the selected group
  always_comb begin
    case (rq_r.group)
      4'h0:    cliIdBad = rq_r.cliId > `UCM_G0_MID_MAX;
      4'h3:    cliIdBad = rq_r.cliId > `UCM_G3_MID_MAX;
      default: cliIdBad = 1'b0;
    endcase
  end

  // Build the answer to the latched request
  always_comb begin
    rsp_nxt = '0;
    doOpen  = 1'b0;
    doClose = 1'b0;
    // RULE22 copy transaction
    rsp_nxt.tid = rq_r.tid;
    // RULE3 destination in header
    rsp_nxt.dst = rq_r.src;
    rsp_nxt.src = myAddr;
    rsp_nxt.rr  = 1'b1;
    // RULE2 reserved bits zero
    rsp_nxt.rsvd    = 4'h0;
    // RULE20 error service code
    rsp_nxt.service = `UCM_SVC_ERROR;
    rsp_nxt.add     = `UCM_ADD_NONE;
    if (rq_r.connected) begin
      // RULE19 echo service code
      rsp_nxt.service = rq_r.service;
      rsp_nxt.add     = `UCM_ADD_OK;
    end else if (rq_r.service == `UCM_SVC_OPEN) begin
      if (rq_r.group > `UCM_GROUP_MAX) begin
        // RULE13 group out of range
        rsp_nxt.gen = `UCM_GEN_BADPAR;
        rsp_nxt.add = `UCM_ADD_RANGE;
      end else if (!GROUPS[rq_r.group[1:0]]) begin
        // RULE12 group unsupported
        rsp_nxt.gen = `UCM_GEN_NORES;
        rsp_nxt.add = `UCM_ADD_GROUP;
      end else if (!hasFree) begin
        // RULE14 connection limit
        rsp_nxt.gen = `UCM_GEN_NORES;
        rsp_nxt.add = `UCM_ADD_NOCONN;
      end else if (cliIdBad) begin
        // RULE15 invalid client ID
        rsp_nxt.gen = `UCM_GEN_BADPAR;
        rsp_nxt.add = `UCM_ADD_BADMID;
      end else if (dupHit) begin
        // RULE15 duplicate client ID
        rsp_nxt.gen = `UCM_GEN_NORES;
        rsp_nxt.add = `UCM_ADD_DUPMID;
      end else if (!idAvail) begin
        // RULE14 pool exhausted
        rsp_nxt.gen = `UCM_GEN_NORES;
        rsp_nxt.add = `UCM_ADD_NOMID;
      end else begin
        doOpen = 1'b1;
        // RULE1 open success code
        rsp_nxt.service = `UCM_SVC_OPEN;
        rsp_nxt.add     = `UCM_ADD_OK;
        // RULE21 body format choice
        rsp_nxt.fmt = (rq_r.fmt <= `UCM_FMT_16_8 && FMTS[rq_r.fmt[1:0]])
                      ? rq_r.fmt : DEF_FMT;
        // RULE4 zero for group 0/3
        rsp_nxt.dstId = (rq_r.group == 4'h1 || rq_r.group == 4'h2)
                        ? allocId + `UCM_MID_W'(POOL) : '0;
        rsp_nxt.srcId = allocId;
        // RULE7 instance identifier
        rsp_nxt.inst = INST_BASE + 16'(freeSlot);
      end
    end else if (rq_r.service == `UCM_SVC_CLOSE) begin
      if (hitFound) begin
        doClose = 1'b1;
        // RULE10 close success
        rsp_nxt.service = `UCM_SVC_CLOSE;
        rsp_nxt.add     = `UCM_ADD_OK;
      end else begin
        // RULE16 unknown instance
        rsp_nxt.gen = `UCM_GEN_NOOBJ;
        rsp_nxt.add = `UCM_ADD_NONE;
      end
    end else begin
      // RULE11 unsupported service
      rsp_nxt.gen = `UCM_GEN_NOSVC;
      rsp_nxt.add = `UCM_ADD_NONE;
    end
  end

  // Handshake and sequencing
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r    <= ucm_pkg::SRV_IDLE;
      reqReady_r <= 1'b0;
      rspValid_r <= 1'b0;
      rsp_r      <= '0;
      rq_r       <= '0;
    end else begin
      case (state_r)
        ucm_pkg::SRV_IDLE: begin
          reqReady_r <= 1'b1;
          // Frames for other nodes and stray responses are dropped
          if (bus.reqValid && reqReady_r) begin
            reqReady_r <= 1'b0;
            if (bus.req.dst == myAddr && !bus.req.rr) begin
              rq_r    <= bus.req;
              state_r <= ucm_pkg::SRV_EVAL;
            end
          end
        end
        ucm_pkg::SRV_EVAL: begin
          rsp_r      <= rsp_nxt;
          rspValid_r <= 1'b1;
          state_r    <= ucm_pkg::SRV_RESP;
        end
        default: begin
          if (bus.rspReady) begin
            rspValid_r <= 1'b0;
            state_r    <= ucm_pkg::SRV_IDLE;
          end
        end
      endcase
    end
  end

  // Connection table updates
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < NCONN; i++) begin
        slotUsed_r[i]  <= 1'b0;
        slotGrp_r[i]   <= 2'h0;
        slotCliId_r[i] <= '0;
        slotCliAd_r[i] <= '0;
        slotSrvId_r[i] <= '0;
      end
    end else if (state_r == ucm_pkg::SRV_EVAL) begin
      // RULE7 create instance
      if (doOpen) begin
        slotUsed_r[freeSlot]  <= 1'b1;
        slotGrp_r[freeSlot]   <= rq_r.group[1:0];
        slotCliId_r[freeSlot] <= rq_r.cliId;
        slotCliAd_r[freeSlot] <= rq_r.src;
        slotSrvId_r[freeSlot] <= allocId;
      end
      // RULE9 delete and free
      if (doClose) begin
        slotUsed_r[hitSlot] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      connCount <= 8'h00;
    end else if (state_r == ucm_pkg::SRV_EVAL) begin
      if (doOpen) begin
        connCount <= connCount + 8'h01;
      end else if (doClose) begin
        connCount <= connCount - 8'h01;
      end
    end
  end

  // Explicit request hand-off to the object layer
  always_ff @(posedge mclk) begin
    if (reset) begin
      objValid   <= 1'b0;
      objService <= '0;
      objClass   <= 16'h0000;
      objInst    <= 16'h0000;
      objToClass <= 1'b0;
    end else begin
      objValid <= (state_r == ucm_pkg::SRV_EVAL) && rq_r.connected;
      if (state_r == ucm_pkg::SRV_EVAL && rq_r.connected) begin
        objService <= rq_r.service;
        // RULE17 field widths by format
        objClass   <= (rq_r.fmt == `UCM_FMT_16_16 || rq_r.fmt == `UCM_FMT_16_8)
                      ? rq_r.cls : {8'h00, rq_r.cls[7:0]};
        objInst    <= (rq_r.fmt == `UCM_FMT_8_16 || rq_r.fmt == `UCM_FMT_16_16)
                      ? rq_r.inst : {8'h00, rq_r.inst[7:0]};
        // RULE18 instance zero is class
        objToClass <= (rq_r.inst == 16'h0000);
      end
    end
  end

endmodule

// [ucm_params.svh]
// Constants shared by both ends of the unconnected connection manager.
// Assumes a single clock domain and message-level (already framed) transfer.
//
// Summary of operation
// RULE1: Open success: response flag 1, service 4b
// RULE2: Transmitter drives reserved response bits zero
// RULE3: Open messages always carry destination node address
// RULE4: Group 0/3: destination ID zero, client ignores
// RULE5: Group 1: client forms ID from returned value
// RULE6: Server allocates source ID, forms transmit ID
// RULE7: Successful open returns 16-bit instance identifier
// RULE8: Close request: flag 0, service 4c, instance
// RULE9: Close deletes existing instance, frees its resources
// RULE10: Close success answers 4c, else error response
// RULE11: Unknown unconnected service gives codes 08/ff
// RULE12: Unsupported group gives codes 02/01
// RULE13: Invalid group select gives codes 20/01
// RULE14: Connection limit 02/02, no IDs 02/03
// RULE15: Bad client ID 20/02, duplicate 02/04
// RULE16: Close of unknown instance gives 16/ff
// RULE17: Class/instance widths follow returned body format
// RULE18: Instance zero addresses the class itself
// RULE19: Explicit success echoes service, flag 1
// RULE20: Error response service 14, ff if none
// RULE21: Echo supported body format, else default
// RULE22: Response copies request transaction identifier
`ifndef UCM_PARAMS_SVH
`define UCM_PARAMS_SVH

`define UCM_ADDR_W      6
`define UCM_TID_W       1
`define UCM_SVC_W       7
`define UCM_MID_W       6
`define UCM_CID_W       11

`define UCM_SVC_OPEN    7'h4b
`define UCM_SVC_CLOSE   7'h4c
`define UCM_SVC_ERROR   7'h14

`define UCM_GEN_NOSVC   8'h08
`define UCM_GEN_NORES   8'h02
`define UCM_GEN_BADPAR  8'h20
`define UCM_GEN_NOOBJ   8'h16
`define UCM_ADD_NONE    8'hff
`define UCM_ADD_GROUP   8'h01
`define UCM_ADD_NOCONN  8'h02
`define UCM_ADD_NOMID   8'h03
`define UCM_ADD_BADMID  8'h02
`define UCM_ADD_DUPMID  8'h04
`define UCM_ADD_RANGE   8'h01
`define UCM_ADD_OK      8'h00

`define UCM_GROUP_MAX   4'h3
`define UCM_G0_MID_MAX  6'h0f
`define UCM_G3_MID_MAX  6'h06

// Body format: class width / instance width
`define UCM_FMT_8_8     4'h0
`define UCM_FMT_8_16    4'h1
`define UCM_FMT_16_16   4'h2
`define UCM_FMT_16_8    4'h3

`endif

// [ucm_pkg.sv]
// Types shared by both ends of the unconnected connection manager.
// Assumes ucm_params.svh is on the include path.
`include "ucm_params.svh"

package ucm_pkg;

  typedef enum logic [1:0] {KIND_OPEN, KIND_CLOSE, KIND_EXPLICIT} ucm_kind_t;

  typedef enum logic [1:0] {SRV_IDLE, SRV_EVAL, SRV_RESP} ucm_srv_state_t;

  typedef enum logic [0:0] {CLI_IDLE, CLI_WAIT} ucm_cli_state_t;

  typedef struct packed {
    logic                   rr;
    logic                   connected;
    logic [`UCM_TID_W-1:0]  tid;
    logic [`UCM_ADDR_W-1:0] dst;
    logic [`UCM_ADDR_W-1:0] src;
    logic [`UCM_SVC_W-1:0]  service;
    logic [3:0]             group;
    logic [3:0]             fmt;
    logic [`UCM_MID_W-1:0]  cliId;
    logic [15:0]            cls;
    logic [15:0]            inst;
  } ucm_req_t;

  typedef struct packed {
    logic                   rr;
    logic [`UCM_TID_W-1:0]  tid;
    logic [`UCM_ADDR_W-1:0] dst;
    logic [`UCM_ADDR_W-1:0] src;
    logic [`UCM_SVC_W-1:0]  service;
    logic [3:0]             rsvd;
    logic [3:0]             fmt;
    logic [`UCM_MID_W-1:0]  dstId;
    logic [`UCM_MID_W-1:0]  srcId;
    logic [15:0]            inst;
    logic [7:0]             gen;
    logic [7:0]             add;
  } ucm_rsp_t;

endpackage

// [ucm_if.sv]
// Message-level link between a client node and the server node.
// Each message is a whole parsed frame; valid stays until ready is seen.
`include "ucm_params.svh"

interface ucm_if;
  logic             reqValid;
  logic             reqReady;
  ucm_pkg::ucm_req_t req;
  logic             rspValid;
  logic             rspReady;
  ucm_pkg::ucm_rsp_t rsp;

  modport server (
    input  reqValid,
    input  req,
    output reqReady,
    output rspValid,
    output rsp,
    input  rspReady
  );

  modport client (
    output reqValid,
    output req,
    input  reqReady,
    input  rspValid,
    input  rsp,
    output rspReady
  );
endinterface

// [ucm_client.sv]
// Client end: issues open, close and explicit requests one at a time.
// Assumes the server answers every accepted request addressed to it.
`include "ucm_params.svh"

module ucm_client (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // Own node address
  input  wire logic [`UCM_ADDR_W-1:0] myAddr,
  // Command from the user
  input  wire logic                   cmdValid,
  output logic                        cmdReady,
  input  wire ucm_pkg::ucm_kind_t     cmdKind,
  input  wire logic [`UCM_ADDR_W-1:0] cmdDst,
  input  wire logic [3:0]             cmdGroup,
  input  wire logic [3:0]             cmdFmt,
  input  wire logic [`UCM_MID_W-1:0]  cmdCliId,
  input  wire logic [`UCM_SVC_W-1:0]  cmdService,
  input  wire logic [15:0]            cmdClass,
  input  wire logic [15:0]            cmdInst,
  // Result to the user
  output logic                        resValid,
  output logic                        resOk,
  output logic [7:0]                  resGen,
  output logic [7:0]                  resAdd,
  output logic [15:0]                 resInst,
  output logic [3:0]                  resFmt,
  output logic [`UCM_CID_W-1:0]       resTxConnId,
  // Link
  ucm_if.client                       bus
);

  ucm_pkg::ucm_cli_state_t state_r;
  ucm_pkg::ucm_req_t       req_r;
  logic                    reqValid_r;
  logic                    rspReady_r;
  logic [`UCM_TID_W-1:0]   tid_r;
  logic [3:0]              group_r;
  logic [3:0]              curFmt_r;
  logic                    match;

  assign bus.reqValid = reqValid_r;
  assign bus.req      = req_r;
  assign bus.rspReady = rspReady_r;

  // RULE22 match by transaction
  assign match = bus.rspValid && rspReady_r && bus.rsp.rr
                 && bus.rsp.tid == req_r.tid && bus.rsp.dst == myAddr;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r    <= ucm_pkg::CLI_IDLE;
      req_r      <= '0;
      reqValid_r <= 1'b0;
      rspReady_r <= 1'b0;
      cmdReady   <= 1'b0;
      tid_r      <= '0;
      group_r    <= 4'h0;
    end else begin
      case (state_r)
        ucm_pkg::CLI_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady      <= 1'b0;
            reqValid_r    <= 1'b1;
            rspReady_r    <= 1'b1;
            tid_r         <= tid_r + `UCM_TID_W'(1);
            group_r       <= cmdGroup;
            state_r       <= ucm_pkg::CLI_WAIT;
            req_r         <= '0;
            req_r.tid     <= tid_r;
            // RULE3 destination in header
            req_r.dst     <= cmdDst;
            req_r.src     <= myAddr;
            // RULE8 close request format
            req_r.rr      <= 1'b0;
            req_r.service <= (cmdKind == ucm_pkg::KIND_OPEN) ? `UCM_SVC_OPEN
                           : (cmdKind == ucm_pkg::KIND_CLOSE) ? `UCM_SVC_CLOSE
                           : cmdService;
            req_r.connected <= (cmdKind == ucm_pkg::KIND_EXPLICIT);
            req_r.group   <= cmdGroup;
            req_r.fmt     <= (cmdKind == ucm_pkg::KIND_EXPLICIT) ? curFmt_r : cmdFmt;
            req_r.cliId   <= (cmdGroup == 4'h1) ? '0 : cmdCliId;
            // RULE17 narrow fields zero-extended
            req_r.cls     <= (curFmt_r == `UCM_FMT_16_16 || curFmt_r == `UCM_FMT_16_8
                              || cmdKind != ucm_pkg::KIND_EXPLICIT)
                             ? cmdClass : {8'h00, cmdClass[7:0]};
            req_r.inst    <= (curFmt_r == `UCM_FMT_8_16 || curFmt_r == `UCM_FMT_16_16
                              || cmdKind != ucm_pkg::KIND_EXPLICIT)
                             ? cmdInst : {8'h00, cmdInst[7:0]};
          end
        end
        default: begin
          if (bus.reqReady) begin
            reqValid_r <= 1'b0;
          end
          if (match) begin
            rspReady_r <= 1'b0;
            state_r    <= ucm_pkg::CLI_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      resValid    <= 1'b0;
      resOk       <= 1'b0;
      resGen      <= 8'h00;
      resAdd      <= 8'h00;
      resInst     <= 16'h0000;
      resFmt      <= 4'h0;
      resTxConnId <= '0;
      curFmt_r    <= `UCM_FMT_8_8;
    end else begin
      resValid <= match;
      if (match) begin
        resOk   <= bus.rsp.service != `UCM_SVC_ERROR;
        resGen  <= bus.rsp.gen;
        resAdd  <= bus.rsp.add;
        resInst <= bus.rsp.inst;
        resFmt  <= bus.rsp.fmt;
        if (bus.rsp.service == `UCM_SVC_OPEN) begin
          curFmt_r <= bus.rsp.fmt;
          // RULE5 group 1 connection ID
          // RULE4 ignore field otherwise
          resTxConnId <= (group_r == 4'h1)
                         ? {1'b0, bus.rsp.dstId[3:0], bus.rsp.src}
                         : {1'b1, 1'b1, req_r.cliId[2:0], myAddr};
        end
      end
    end
  end

endmodule

// [ucm_link_monitor.sv]
// Checker for the message link between client and server ends.
// Assumes one mclk domain and that SRV_ADDR is the server's node address.
`include "ucm_params.svh"

module ucm_link_monitor #(
  parameter logic [5:0]  SRV_ADDR  = 6'h05,
  parameter logic [15:0] INST_BASE = 16'h0010,
  parameter int          NCONN     = 4
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              reset,
  // Link
  input wire logic              reqValid,
  input wire logic              reqReady,
  input wire ucm_pkg::ucm_req_t req,
  input wire logic              rspValid,
  input wire logic              rspReady,
  input wire ucm_pkg::ucm_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  ucm_pkg::ucm_req_t lastReq_r;
  logic              take;

  assign take = reqValid && reqReady;

  // Answers are judged against the request that was taken, not the live bus
  always_ff @(posedge mclk) begin
    if (reset) begin
      lastReq_r <= '0;
    end else if (take) begin
      lastReq_r <= req;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_tid_copy: assert property (take && req.dst == SRV_ADDR && !req.rr
    |-> ##[1:3] (rspValid && rsp.tid == lastReq_r.tid)) else $error("tid not copied");
  a_hdr_addr: assert property (rspValid
    |-> rsp.rr && rsp.src == SRV_ADDR && rsp.dst == lastReq_r.src) else $error("bad header");
  a_rsvd_zero: assert property (rspValid |-> rsp.rsvd == 4'h0)
    else $error("reserved bits set");
  a_open_ok: assert property (rspValid && rsp.service == `UCM_SVC_OPEN
    |-> lastReq_r.service == `UCM_SVC_OPEN && rsp.gen == 8'h00
    && rsp.inst >= INST_BASE && rsp.inst < INST_BASE + NCONN) else $error("bad open answer");
  a_dstid_zero: assert property (rspValid && rsp.service == `UCM_SVC_OPEN
    && lastReq_r.group inside {4'h0, 4'h3} |-> rsp.dstId == 6'h00) else $error("dstId set");
  a_bad_svc: assert property (rspValid && !lastReq_r.connected
    && !(lastReq_r.service inside {`UCM_SVC_OPEN, `UCM_SVC_CLOSE})
    |-> {rsp.service, rsp.gen, rsp.add} == {7'h14, 8'h08, 8'hff}) else $error("bad 08 code");
  a_grp_range: assert property (rspValid && !lastReq_r.connected
    && lastReq_r.service == `UCM_SVC_OPEN && lastReq_r.group > 4'h3
    |-> {rsp.service, rsp.gen, rsp.add} == {7'h14, 8'h20, 8'h01}) else $error("bad 20 code");
  a_grp_unsup: assert property (rspValid && !lastReq_r.connected
    && lastReq_r.service == `UCM_SVC_OPEN && lastReq_r.group == 4'h2
    |-> {rsp.service, rsp.gen, rsp.add} == {7'h14, 8'h02, 8'h01}) else $error("bad 02 code");
  a_echo_svc: assert property (rspValid && lastReq_r.connected
    |-> rsp.service == lastReq_r.service && rsp.gen == 8'h00) else $error("service not echoed");

  c_open: cover property (rspValid && rspReady && rsp.service == `UCM_SVC_OPEN);
  c_close: cover property (rspValid && rspReady && rsp.service == `UCM_SVC_CLOSE);
  c_error: cover property (rspValid && rspReady && rsp.service == `UCM_SVC_ERROR);
endmodule

// [tb.sv]
// Self-checking bench: client and server face each other on one link, and a
// second server is driven directly by the bench with services it must refuse.
`include "ucm_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] gen; logic [7:0] add; logic chk; logic [15:0] inst; logic [3:0] fmt;
    logic [10:0] tx;
  } ucm_exp_t;
  localparam logic [5:0] SRV = 6'h05;
  localparam logic [5:0] CLI = 6'h21;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cmdValid = 1'b0;
  logic [1:0] cmdKindBits = 2'h0;
  logic [3:0] cmdGroup = 4'h0, cmdFmt = 4'h0;
  logic [5:0] cmdCliId = 6'h00;
  logic [6:0] cmdService = 7'h00;
  logic [15:0] cmdClass = 16'h0000, cmdInst = 16'h0000;
  logic cmdReady, resValid, resOk, objValid, objToClass;
  logic [7:0] resGen, resAdd, connCount;
  logic [15:0] resInst, objClass, objInst;
  logic [3:0] resFmt;
  logic [10:0] resTxConnId;
  logic [6:0] objService;
  int errors = 0, comparisons = 0;
  ucm_exp_t resQ[$];
  logic [39:0] objQ[$];
  ucm_exp_t w;
  ucm_if bus();
  ucm_if bus2();

  ucm_server #(.NCONN(5)) i_ucm_server (.mclk(mclk), .reset(reset), .myAddr(SRV), .bus(bus),
    .objValid(objValid), .objService(objService), .objClass(objClass), .objInst(objInst),
    .objToClass(objToClass), .connCount(connCount));
  ucm_server i_ucm_server_b (.mclk(mclk), .reset(reset), .myAddr(SRV), .bus(bus2),
    .objValid(), .objService(), .objClass(), .objInst(), .objToClass(), .connCount());
  ucm_client i_ucm_client (.mclk(mclk), .reset(reset), .myAddr(CLI), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(ucm_pkg::ucm_kind_t'(cmdKindBits)), .cmdDst(SRV),
    .cmdGroup(cmdGroup), .cmdFmt(cmdFmt), .cmdCliId(cmdCliId), .cmdService(cmdService),
    .cmdClass(cmdClass), .cmdInst(cmdInst), .resValid(resValid), .resOk(resOk),
    .resGen(resGen), .resAdd(resAdd), .resInst(resInst), .resFmt(resFmt),
    .resTxConnId(resTxConnId), .bus(bus));
  ucm_link_monitor #(.SRV_ADDR(SRV), .INST_BASE(16'h0010), .NCONN(5)) i_ucm_link_monitor (
    .mclk(mclk), .reset(reset), .reqValid(bus.reqValid), .reqReady(bus.reqReady),
    .req(bus.req), .rspValid(bus.rspValid), .rspReady(bus.rspReady), .rsp(bus.rsp));

  always #5 mclk = ~mclk;

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [47:0] ex, input logic [47:0] got);
    comparisons++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  function automatic ucm_exp_t ex(input logic [7:0] g, input logic [7:0] a);
    return '{g, a, 1'b0, 16'h0000, 4'h0, 11'h000};
  endfunction

  function automatic ucm_exp_t okx(input logic [15:0] i, input logic [3:0] f,
                                   input logic [10:0] t);
    return '{8'h00, 8'h00, 1'b1, i, f, t};
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Requests are raised at a falling edge and held until taken
  task automatic cmd(input logic [1:0] k, input logic [3:0] g, input logic [3:0] f,
                     input logic [5:0] c, input logic [6:0] s, input logic [15:0] cl,
                     input logic [15:0] in, input ucm_exp_t e);
    int n;
    @(negedge mclk);
    {cmdKindBits, cmdGroup, cmdFmt, cmdCliId, cmdService, cmdClass, cmdInst} =
      {k, g, f, c, s, cl, in};
    cmdValid = 1'b1;
    resQ.push_back(e);
    for (n = 0; n < 50 && cmdReady !== 1'b1; n++) @(negedge mclk);
    if (n == 50) check("cmdReady", 1, 0);
    if (n == 50) stop_test();
    @(negedge mclk);
    cmdValid = 1'b0;
  endtask

  always @(negedge mclk) begin
    if (resValid === 1'b1 && resQ.size() == 0) check("extra result", 0, 1);
    if (resValid === 1'b1 && resQ.size() != 0) begin
      w = resQ.pop_front();
      check("resOk", w.gen == 8'h00, resOk);
      check("resGen", w.gen, resGen);
      check("resAdd", w.add, resAdd);
      if (w.chk) check("resInst", w.inst, resInst);
      if (w.chk) check("resFmt", w.fmt, resFmt);
      if (w.chk) check("resTxConnId", w.tx, resTxConnId);
    end
    if (objValid === 1'b1) check("obj", objQ.pop_front(),
      {objService, objClass, objInst, objToClass});
    if (bus.rspValid === 1'b1) check("rsp hdr", {SRV, CLI, 4'h0},
      {bus.rsp.src, bus.rsp.dst, bus.rsp.rsvd});
    if (bus.reqValid === 1'b1 && bus.req.service === `UCM_SVC_CLOSE)
      check("close req", 2'b00, {bus.req.rr, bus.req.connected});
  end

  initial begin
    int n;
    logic [15:0] r, cl, in;
    logic [6:0] sv;
    bus2.reqValid = 1'b0;
    bus2.rspReady = 1'b1;
    bus2.req = '0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    cmd(ucm_pkg::KIND_OPEN, 4'h0, 4'h1, 6'h03, 7'h00, 16'h0, 16'h0,
        okx(16'h0010, 4'h1, {2'b11, 3'h3, CLI}));
    cmd(ucm_pkg::KIND_OPEN, 4'h0, 4'h1, 6'h03, 7'h00, 16'h0, 16'h0, ex(8'h02, 8'h04));
    cmd(ucm_pkg::KIND_OPEN, 4'h3, 4'h0, 6'h07, 7'h00, 16'h0, 16'h0, ex(8'h20, 8'h02));
    cmd(ucm_pkg::KIND_OPEN, 4'h2, 4'h0, 6'h01, 7'h00, 16'h0, 16'h0, ex(8'h02, 8'h01));
    cmd(ucm_pkg::KIND_OPEN, 4'h4, 4'h0, 6'h01, 7'h00, 16'h0, 16'h0, ex(8'h20, 8'h01));
    $display("test open errors done");
    r = 16'hbf85;
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      cl = r;
      r = lfsr(r);
      in = (i == 0) ? 16'h0000 : r;
      sv = 7'h0e + 7'(i);
      objQ.push_back({sv, 8'h00, cl[7:0], in, in == 16'h0000});
      cmd(ucm_pkg::KIND_EXPLICIT, 4'h0, 4'h0, 6'h00, sv, cl, in, ex(8'h00, 8'h00));
    end
    cmd(2'h3, 4'h0, 4'h0, 6'h00, 7'h0e, 16'h0, 16'h0, ex(8'h08, 8'hff));
    $display("test explicit done");
    cmd(ucm_pkg::KIND_CLOSE, 4'h0, 4'h0, 6'h00, 7'h00, 16'h0, 16'h0010, ex(8'h00, 8'h00));
    cmd(ucm_pkg::KIND_CLOSE, 4'h0, 4'h0, 6'h00, 7'h00, 16'h0, 16'h0010, ex(8'h16, 8'hff));
    $display("test close done");
    for (int i = 0; i < 4; i++)
      cmd(ucm_pkg::KIND_OPEN, 4'h1, 4'h3, 6'h00, 7'h00, 16'h0, 16'h0,
          okx(16'h0010 + 16'(i), 4'h0, {1'b0, 4'(i + 4), SRV}));
    cmd(ucm_pkg::KIND_OPEN, 4'h1, 4'h0, 6'h00, 7'h00, 16'h0, 16'h0, ex(8'h02, 8'h03));
    cmd(ucm_pkg::KIND_OPEN, 4'h3, 4'h0, 6'h02, 7'h00, 16'h0, 16'h0,
        okx(16'h0014, 4'h0, {2'b11, 3'h2, CLI}));
    cmd(ucm_pkg::KIND_OPEN, 4'h0, 4'h0, 6'h01, 7'h00, 16'h0, 16'h0, ex(8'h02, 8'h02));
    for (n = 0; n < 100 && resQ.size() + objQ.size() != 0; n++) @(negedge mclk);
    check("drained", 0, resQ.size() + objQ.size());
    check("connCount", 8'h05, connCount);
    $display("test pools done");
    foreach (objQ[i]) objQ.delete(i);
    for (int i = 0; i < 2; i++) begin
      @(negedge mclk);
      bus2.req = '{dst: SRV, src: CLI, service: (i == 0) ? 7'h0e : 7'h4d, default: '0};
      bus2.reqValid = 1'b1;
      for (n = 0; n < 50 && bus2.reqReady !== 1'b1; n++) @(negedge mclk);
      @(negedge mclk);
      bus2.reqValid = 1'b0;
      for (n = 0; n < 50 && bus2.rspValid !== 1'b1; n++) @(negedge mclk);
      check("err rsp", {1'b1, 7'h14, 8'h08, 8'hff},
            {bus2.rspValid, bus2.rsp.service, bus2.rsp.gen, bus2.rsp.add});
      @(negedge mclk);
    end
    $display("test unknown service done");
    stop_test();
  end
endmodule
